// >>> design/prescaler_select_top.sv
// Real-time counter with clock select, prescaler, modulo compare and APB registers
//
// What this block does
// - Interrupt request only when enable bit set
// - Reserved control bits read zero, ignore writes
// - Toggle enable inverts output on each overflow
// - Source 00 external, 01 slow, else bus
// - Changed clock source clears prescaler and counter
// - Reset selects external clock source
// - Prescaler codes give binary or decimal ratios
// - Changed prescaler code clears prescaler and counter
// - Reset turns prescaler off
// - Count matching limit wraps and sets flag
// - Zero limit flags every prescaler output edge
// - Reset clears both limit bytes
// - Low count read locks value for high
// - Writes to count bytes are ignored
// - Count clears on reset and setting change
// - Writing one clears flag; flag and enable interrupt
// - Count advances per prescaler tick, wraps, continues
// - New limit takes effect at overflow or start
// - Toggle output starts high after reset
//
// Implementation choice: the APB register port.
`default_nettype none
module prescaler_select_top (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB request
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  // APB answer
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Clock sources from outside the bus domain
  input  wire logic        ext_osc_clk,
  input  wire logic        low_power_clk,
  // Interrupt request and toggle pin
  output logic             match_irq,
  output logic             toggle_out
);

  // All state of the block
  typedef struct packed {
    logic [2:0]  ext_sync;
    logic        ext_level;
    logic [2:0]  lpo_sync;
    logic        lpo_level;
    logic [1:0]  clock_source_select;
    logic [2:0]  prescaler_select;
    logic        match_irq_enable;
    logic        toggle_output_enable;
    logic        match_flag;
    logic        toggle_level;
    logic [7:0]  compare_limit_hi_byte;
    logic [7:0]  compare_limit_lo_byte;
    logic [15:0] limit_active;
    logic [10:0] div_count;
    logic [15:0] main_count;
    logic [15:0] locked_count;
    logic        locked;
    logic [31:0] rdata;
  } prescaler_select_state_t;

  prescaler_select_state_t cur_ff;
  prescaler_select_state_t nxt_ff;

  logic [15:0] word_idx;
  logic        mapped;
  logic        setup_rd;
  logic        acc;
  logic        wr_ok;
  logic        rd_ok;
  logic        ext_rise;
  logic        lpo_rise;
  logic        src_tick;
  logic        pre_tick;
  logic [1:0]  wr_src;
  logic [2:0]  wr_ps;
  logic        settings_change;
  logic [7:0]  rd_byte;

  // Address decode and access qualifiers
  assign word_idx = paddr[17:2];
  assign mapped   = (word_idx >= prescaler_select_pkg::IDX_FLAG_ENABLE_CONTROL) &&
                    (word_idx <= prescaler_select_pkg::IDX_COUNT_VALUE_LOW) && (paddr[1:0] == 2'h0);
  assign acc      = psel && penable;
  assign setup_rd = psel && !penable && !pwrite;
  assign wr_ok    = acc && pwrite && mapped && pstrb[0];
  assign rd_ok    = acc && !pwrite && mapped;

  // Handshake answers at once in the access phase
  assign pready   = 1'b1;
  assign pslverr  = acc && !mapped;
  assign prdata   = cur_ff.rdata;

  // Outputs
  assign match_irq  = cur_ff.match_flag && cur_ff.match_irq_enable;
  assign toggle_out = cur_ff.toggle_level;

  // Synchronised rising edges; a change counts when stages two and three agree
  assign ext_rise = cur_ff.ext_sync[1] && cur_ff.ext_sync[2] && !cur_ff.ext_level;
  assign lpo_rise = cur_ff.lpo_sync[1] && cur_ff.lpo_sync[2] && !cur_ff.lpo_level;

  // Prescaler input selection
  always_comb begin
    unique case (cur_ff.clock_source_select)
      prescaler_select_pkg::SRC_EXTERNAL:  src_tick = ext_rise;
      prescaler_select_pkg::SRC_LOW_POWER: src_tick = lpo_rise;
      default:                  src_tick = 1'b1;
    endcase
  end

  // Prescaler output tick
  assign pre_tick = src_tick && (cur_ff.prescaler_select != prescaler_select_pkg::PRESCALER_OFF) &&
                    (cur_ff.div_count == prescaler_select_pkg::prescaler_select_div_last(cur_ff.prescaler_select,
                                                      cur_ff.clock_source_select[0]));

  // Fields of a write to the second control register
  assign wr_src = pwdata[prescaler_select_pkg::POS_CLOCK_SOURCE_LSB +: 2];
  assign wr_ps  = pwdata[prescaler_select_pkg::POS_PRESCALER_LSB +: 3];
  assign settings_change = wr_ok && (word_idx == prescaler_select_pkg::IDX_CLOCK_PRESCALE_SEL) &&
                           ((wr_src != cur_ff.clock_source_select) ||
                            (wr_ps != cur_ff.prescaler_select));

  // Read data byte for the addressed register
  always_comb begin
    rd_byte = 8'h00;
    unique case (word_idx)
      prescaler_select_pkg::IDX_FLAG_ENABLE_CONTROL: begin
        rd_byte[prescaler_select_pkg::POS_MATCH_FLAG]           = cur_ff.match_flag;
        rd_byte[prescaler_select_pkg::POS_MATCH_IRQ_ENABLE]     = cur_ff.match_irq_enable;
        rd_byte[prescaler_select_pkg::POS_TOGGLE_OUTPUT_ENABLE] = cur_ff.toggle_output_enable;
      end
      prescaler_select_pkg::IDX_CLOCK_PRESCALE_SEL: begin
        rd_byte[prescaler_select_pkg::POS_CLOCK_SOURCE_LSB +: 2] = cur_ff.clock_source_select;
        rd_byte[prescaler_select_pkg::POS_PRESCALER_LSB +: 3]    = cur_ff.prescaler_select;
      end
      prescaler_select_pkg::IDX_COMPARE_LIMIT_HIGH: rd_byte = cur_ff.compare_limit_hi_byte;
      prescaler_select_pkg::IDX_COMPARE_LIMIT_LOW:  rd_byte = cur_ff.compare_limit_lo_byte;
      prescaler_select_pkg::IDX_COUNT_VALUE_HIGH:
        rd_byte = cur_ff.locked ? cur_ff.locked_count[15:8] : cur_ff.main_count[15:8];
      prescaler_select_pkg::IDX_COUNT_VALUE_LOW:    rd_byte = cur_ff.main_count[7:0];
      default:                           rd_byte = 8'h00;
    endcase
  end

  // Next-state logic
  always_comb begin
    nxt_ff = cur_ff;

    // Three-stage synchronisers and agreed levels
    nxt_ff.ext_sync = {cur_ff.ext_sync[1:0], ext_osc_clk};
    nxt_ff.lpo_sync = {cur_ff.lpo_sync[1:0], low_power_clk};
    if (cur_ff.ext_sync[1] == cur_ff.ext_sync[2]) begin
      nxt_ff.ext_level = cur_ff.ext_sync[2];
    end
    if (cur_ff.lpo_sync[1] == cur_ff.lpo_sync[2]) begin
      nxt_ff.lpo_level = cur_ff.lpo_sync[2];
    end

    // Read data captured in the setup cycle
    if (setup_rd) begin
      nxt_ff.rdata = {24'h000000, rd_byte};
    end

    // Prescaler divider
    if (src_tick && cur_ff.prescaler_select != prescaler_select_pkg::PRESCALER_OFF) begin
      nxt_ff.div_count = pre_tick ? 11'h000 : cur_ff.div_count + 11'h001;
    end

    // Main counter, compare and overflow effects
    if (pre_tick) begin
      if (cur_ff.main_count == cur_ff.limit_active) begin
        nxt_ff.main_count   = prescaler_select_pkg::RST_COUNT;
        nxt_ff.match_flag   = 1'b1;
        nxt_ff.limit_active = {cur_ff.compare_limit_hi_byte, cur_ff.compare_limit_lo_byte};
        if (cur_ff.toggle_output_enable) begin
          nxt_ff.toggle_level = !cur_ff.toggle_level;
        end
      end else begin
        nxt_ff.main_count = cur_ff.main_count + 16'h0001;
      end
    end

    // Register writes; count registers take no write
    if (wr_ok) begin
      unique case (word_idx)
        prescaler_select_pkg::IDX_FLAG_ENABLE_CONTROL: begin
          nxt_ff.match_irq_enable     = pwdata[prescaler_select_pkg::POS_MATCH_IRQ_ENABLE];
          nxt_ff.toggle_output_enable = pwdata[prescaler_select_pkg::POS_TOGGLE_OUTPUT_ENABLE];
          if (pwdata[prescaler_select_pkg::POS_MATCH_FLAG] && !(pre_tick &&
              cur_ff.main_count == cur_ff.limit_active)) begin
            nxt_ff.match_flag = 1'b0;
          end
        end
        prescaler_select_pkg::IDX_CLOCK_PRESCALE_SEL: begin
          nxt_ff.clock_source_select = wr_src;
          nxt_ff.prescaler_select    = wr_ps;
          if (wr_ps != prescaler_select_pkg::PRESCALER_OFF) begin
            nxt_ff.limit_active = {cur_ff.compare_limit_hi_byte, cur_ff.compare_limit_lo_byte};
          end
        end
        prescaler_select_pkg::IDX_COMPARE_LIMIT_HIGH: nxt_ff.compare_limit_hi_byte = pwdata[7:0];
        prescaler_select_pkg::IDX_COMPARE_LIMIT_LOW:  nxt_ff.compare_limit_lo_byte = pwdata[7:0];
        default: ;
      endcase
    end

    // Changed source or prescaler restarts prescaler and count
    if (settings_change) begin
      nxt_ff.div_count  = 11'h000;
      nxt_ff.main_count = prescaler_select_pkg::RST_COUNT;
    end

    // Low byte read locks the count in the same cycle its byte is captured, high byte read releases it
    if (setup_rd && word_idx == prescaler_select_pkg::IDX_COUNT_VALUE_LOW) begin
      nxt_ff.locked_count = cur_ff.main_count;
      nxt_ff.locked       = 1'b1;
    end else if (rd_ok && word_idx == prescaler_select_pkg::IDX_COUNT_VALUE_HIGH) begin
      nxt_ff.locked       = 1'b0;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff                       <= '0;
      cur_ff.clock_source_select   <= prescaler_select_pkg::RST_CLOCK_SOURCE;
      cur_ff.prescaler_select      <= prescaler_select_pkg::RST_PRESCALER;
      cur_ff.compare_limit_hi_byte <= prescaler_select_pkg::RST_COMPARE_LIMIT[15:8];
      cur_ff.compare_limit_lo_byte <= prescaler_select_pkg::RST_COMPARE_LIMIT[7:0];
      cur_ff.limit_active          <= prescaler_select_pkg::RST_COMPARE_LIMIT;
      cur_ff.main_count            <= prescaler_select_pkg::RST_COUNT;
      cur_ff.toggle_level          <= prescaler_select_pkg::RST_TOGGLE_LEVEL;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

endmodule // prescaler_select_top
`default_nettype wire

// >>> design/prescaler_select_pkg.sv
// Package: register map, field layout, reset values and divider table of the real-time counter
`default_nettype none
package prescaler_select_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_FLAG_ENABLE_CONTROL  = 16'h306a;
  localparam logic [15:0] IDX_CLOCK_PRESCALE_SEL   = 16'h306b;
  localparam logic [15:0] IDX_COMPARE_LIMIT_HIGH   = 16'h306c;
  localparam logic [15:0] IDX_COMPARE_LIMIT_LOW    = 16'h306d;
  localparam logic [15:0] IDX_COUNT_VALUE_HIGH     = 16'h306e;
  localparam logic [15:0] IDX_COUNT_VALUE_LOW      = 16'h306f;
  // Field positions in the first control register
  localparam int unsigned POS_MATCH_FLAG           = 7;
  localparam int unsigned POS_MATCH_IRQ_ENABLE     = 6;
  localparam int unsigned POS_TOGGLE_OUTPUT_ENABLE = 4;
  // Field positions in the second control register
  localparam int unsigned POS_CLOCK_SOURCE_LSB     = 6;
  localparam int unsigned POS_PRESCALER_LSB        = 0;
  // Clock source codes
  localparam logic [1:0]  SRC_EXTERNAL             = 2'h0;
  localparam logic [1:0]  SRC_LOW_POWER            = 2'h1;
  // Reset values and the prescaler off code
  localparam logic [1:0]  RST_CLOCK_SOURCE         = 2'h0;
  localparam logic [2:0]  RST_PRESCALER            = 3'h0;
  localparam logic [15:0] RST_COMPARE_LIMIT        = 16'h0000;
  localparam logic [15:0] RST_COUNT                = 16'h0000;
  localparam logic        RST_TOGGLE_LEVEL         = 1'b1;
  localparam logic [2:0]  PRESCALER_OFF            = 3'h0;

  // Division ratio minus one, by prescaler code and low clock-source bit
  function automatic logic [10:0] prescaler_select_div_last(input logic [2:0] ps, input logic hi);
    logic [10:0] r;
    r = 11'h000;
    unique case ({hi, ps})
      4'h1: r = 11'h000;
      4'h2: r = 11'h001;
      4'h3: r = 11'h003;
      4'h4: r = 11'h007;
      4'h5: r = 11'h00f;
      4'h6: r = 11'h01f;
      4'h7: r = 11'h03f;
      4'h9: r = 11'h07f;
      4'ha: r = 11'h0ff;
      4'hb: r = 11'h1ff;
      4'hc: r = 11'h3ff;
      4'hd: r = 11'h7ff;
      4'he: r = 11'h063;
      4'hf: r = 11'h3e7;
      default: r = 11'h000;
    endcase
    return r;
  endfunction
endpackage
`default_nettype wire

// >>> verif/prescaler_select_top_monitor.sv
// Port checker of the real-time counter
`default_nettype none
module prescaler_select_top_monitor (
  // APB side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Sources and outputs
  input wire logic        ext_osc_clk,
  input wire logic        low_power_clk,
  input wire logic        match_irq,
  input wire logic        toggle_out
);
  localparam logic [17:0] A_CTL = {prescaler_select_pkg::IDX_FLAG_ENABLE_CONTROL, 2'h0};
  localparam logic [17:0] A_SC2 = {prescaler_select_pkg::IDX_CLOCK_PRESCALE_SEL, 2'h0};
  logic       acc, wr, rd, mapped, ie_ff, te_ff;
  logic [7:0] sh_ff;
  // Access decode
  assign acc = psel && penable;
  assign wr = acc && pwrite && pstrb[0];
  assign rd = acc && !pwrite;
  assign mapped = paddr[1:0] == 2'h0 && paddr[17:2] >= prescaler_select_pkg::IDX_FLAG_ENABLE_CONTROL
                  && paddr[17:2] <= prescaler_select_pkg::IDX_COUNT_VALUE_LOW;
  // Shadow of written control fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_ff <= 1'b0;
      te_ff <= 1'b0;
      sh_ff <= 8'h00;
    end else if (wr && paddr == A_CTL) begin
      ie_ff <= pwdata[6];
      te_ff <= pwdata[4];
    end else if (wr && paddr == A_SC2) begin
      sh_ff <= pwdata[7:0] & 8'hc7;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; pready; endproperty
  property p_err; acc |-> pslverr == !mapped; endproperty
  property p_rsv1; rd && paddr == A_CTL |-> prdata[31:8] == 24'h0 && prdata[5] == 1'b0; endproperty
  property p_sc2; rd && paddr == A_SC2 |-> prdata == {24'h0, sh_ff}; endproperty
  property p_ion; match_irq |-> ie_ff; endproperty
  property p_ioff; wr && paddr == A_CTL && !pwdata[6] |=> !match_irq; endproperty
  property p_trst; disable iff (1'b0) !presetn |-> toggle_out; endproperty
  property p_thold; !$past(te_ff) |-> $stable(toggle_out); endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  a_err: assert property (p_err) else $error("pslverr wrong for address");
  a_rsv1: assert property (p_rsv1) else $error("reserved control bit set");
  a_sc2: assert property (p_sc2) else $error("source or prescaler readback wrong");
  a_ion: assert property (p_ion) else $error("request without enable");
  a_ioff: assert property (p_ioff) else $error("request after disable");
  a_trst: assert property (p_trst) else $error("pin low in reset");
  a_thold: assert property (p_thold) else $error("pin moved while disabled");
  c_clr: cover property (wr && paddr == A_CTL && pwdata[7]);
  c_tog: cover property ($changed(toggle_out));
  c_err: cover property (pslverr);
endmodule // prescaler_select_top_monitor
bind prescaler_select_top prescaler_select_top_monitor u_prescaler_select_top_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_osc_clk(ext_osc_clk), .low_power_clk(low_power_clk),
  .match_irq(match_irq), .toggle_out(toggle_out));
`default_nettype wire

// >>> verif/prescaler_select_top_test.sv
// Self-checking bench of the real-time counter
`default_nettype none
module prescaler_select_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] CTL = prescaler_select_pkg::IDX_FLAG_ENABLE_CONTROL;
  localparam logic [15:0] SC2 = prescaler_select_pkg::IDX_CLOCK_PRESCALE_SEL;
  localparam logic [15:0] CLO = prescaler_select_pkg::IDX_COUNT_VALUE_LOW;
  localparam logic [15:0] CHI = prescaler_select_pkg::IDX_COUNT_VALUE_HIGH;
  logic        pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic        ext_osc_clk = 1'b0, low_power_clk = 1'b0, pready, pslverr, match_irq, toggle_out;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] c;
  logic [7:0]  lo;
  logic [1:0]  sel;
  logic [2:0]  ps;
  int          num_errors = 0, n_tests = 0, n, lim;
  // Bus clock and two slow sources
  always #50 pclk = ~pclk;
  initial #37 forever #500 ext_osc_clk = ~ext_osc_clk;
  initial #81 forever #700 low_power_clk = ~low_power_clk;
  prescaler_select_top u_prescaler_select_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_osc_clk(ext_osc_clk), .low_power_clk(low_power_clk), .match_irq(match_irq), .toggle_out(toggle_out));
  // Verdict and end of run
  task automatic stop_test();
    $display("Compares %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, setup then access until pready
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    if (k >= 100) begin
      num_errors++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Cycles until the pin changes
  task automatic tog_wait(output int cyc);
    logic t;
    t = toggle_out;
    cyc = 0;
    while (toggle_out === t) begin
      @(posedge pclk);
      cyc++;
      if (cyc > 20000) begin
        num_errors++;
        stop_test();
      end
    end
  endtask
  // Overflow period in bus cycles
  function automatic int per(input logic [1:0] s, input logic [2:0] p, input int l);
    int dx1[8] = '{0, 128, 256, 512, 1024, 2048, 100, 1000};
    int d;
    d = s[0] ? dx1[p] : (1 << (p - 1));
    return (l + 1) * d * (s == 2'h0 ? 10 : s == 2'h1 ? 14 : 1);
  endfunction
  initial begin
    presetn <= 1'b0;
    void'($urandom(67654));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, CTL + 16'(i), 8'h00);
      chk(rd, 32'h0);
    end
    apb(1'b1, CTL, 8'hff);
    apb(1'b0, CTL, 8'h00);
    chk(rd, 32'h50);
    apb(1'b1, SC2, 8'h38);
    apb(1'b0, SC2, 8'h00);
    chk(rd, 32'h0);
    apb(1'b1, CLO, 8'h5a);
    apb(1'b0, 16'h3070, 8'h00);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, CLO, 8'h00);
    chk(rd, 32'h0);
    $display("Reset and access test done");
    // Every prescaler code 1 to 7 for sources 00, 10 and 11, code 6 only for source 01, small random limits
    for (int r = 0; r < 22; r++) begin
      sel = r < 7 ? 2'h0 : r == 7 ? 2'h1 : r < 15 ? 2'h2 : 2'h3;
      ps = r < 7 ? 3'(r + 1) : r == 7 ? 3'h6 : 3'((r - 8) % 7 + 1);
      lim = $urandom_range(0, 2);
      apb(1'b1, prescaler_select_pkg::IDX_COMPARE_LIMIT_LOW, 8'(lim));
      apb(1'b1, CTL, sel == 2'h2 ? 8'h90 : 8'hd0);
      apb(1'b1, SC2, {sel, 3'h0, ps});
      tog_wait(n);
      tog_wait(n);
      chk(32'(n), 32'(per(sel, ps, lim)));
      chk({31'h0, match_irq}, {31'h0, sel != 2'h2});
      if (sel == 2'h3) begin
        apb(1'b1, CTL, 8'hd0);
        chk({31'h0, match_irq}, 32'h0);
      end
    end
    $display("Period test done");
    // Locked pairs of count reads around an ignored write
    apb(1'b1, prescaler_select_pkg::IDX_COMPARE_LIMIT_HIGH, 8'h01);
    apb(1'b1, prescaler_select_pkg::IDX_COMPARE_LIMIT_LOW, 8'hff);
    apb(1'b1, SC2, 8'h81);
    repeat (8) begin
      repeat ($urandom_range(0, 40)) @(posedge pclk);
      apb(1'b0, CLO, 8'h00);
      lo = rd[7:0];
      apb(1'b1, CLO, 8'h00);
      apb(1'b0, CHI, 8'h00);
      c = {rd[7:0], lo};
      apb(1'b0, CLO, 8'h00);
      lo = rd[7:0];
      apb(1'b0, CHI, 8'h00);
      chk({16'h0, rd[7:0], lo}, {16'h0, (c + 16'h0009) % 16'h0200});
    end
    apb(1'b1, SC2, 8'h80);
    apb(1'b0, CLO, 8'h00);
    chk(rd, 32'h0);
    $display("Count read test done");
    stop_test();
  end
endmodule // prescaler_select_top_test
`default_nettype wire
